// file: logic/hfs_defs.vh
`ifndef HFS_DEFS_VH
`define HFS_DEFS_VH
// apb byte offsets
`define HFS_REG_CTRL 8'h00
`define HFS_REG_STAT 8'h04
`define HFS_REG_ERR 8'h08
// control register fields and reset value
`define HFS_CTRL_DRY 0
`define HFS_CTRL_RST 1'h0
// clock and time base
`define HFS_CLK_HZ 25000000
`define HFS_TICK_MS 1000
`define HFS_FLASH_MS 100
// durations in seconds, one count per second tick
`define HFS_T_RUNUP 8'h0C
`define HFS_T_VALVE 8'h01
`define HFS_T_NOFLAME 8'h19
`define HFS_T_NOCOMB 8'h0A
`define HFS_T_UV_B 8'h0C
`define HFS_T_UV_E 8'h14
`define HFS_T_RD_B 8'h5A
`define HFS_T_RD_E 8'h78
`define HFS_T_FL_RD 8'h1E
`define HFS_T_XTRA 8'h5A
// event counts
`define HFS_START_TRIES 4'h2
`define HFS_FO_LIMIT 4'h5
`define HFS_START_LOCK 4'h8
`define HFS_FAULT_LIMIT 4'h3
`define HFS_SHORT_PULSES 4'h5
// flash timing in 100 ms units
`define HFS_FL_SHORT 8'h03
`define HFS_FL_LONG 8'h08
`define HFS_FL_GAP 8'h04
`define HFS_FL_PAUSE 8'h0F
// supervisor states
`define HFS_ST_OFF 4'h0
`define HFS_ST_RUNUP 4'h1
`define HFS_ST_IGN 4'h2
`define HFS_ST_FWAIT 4'h3
`define HFS_ST_HEAT 4'h4
`define HFS_ST_CIDLE 4'h5
`define HFS_ST_RDN 4'h6
`define HFS_ST_FRDN 4'h7
`define HFS_ST_HOLD 4'h8
// error numbers
`define HFS_E_NOSTART 4'h1
`define HFS_E_FLAMEOUT 4'h2
`define HFS_E_VOLT 4'h3
`define HFS_E_FOREIGN 4'h4
`define HFS_E_FSENS 4'h5
`define HFS_E_TSENS 4'h6
`define HFS_E_VALVE 4'h7
`define HFS_E_FAN 4'h8
`define HFS_E_PUMP 4'h9
`define HFS_E_LIMIT 4'hA
`define HFS_E_IGN 4'hB
`define HFS_E_LOCK 4'hC
`endif

// file: logic/hfs_supervisor.v
// Chosen here: the APB slave port and the placing of the registers.
`include "hfs_defs.vh"
`default_nettype none
// Summary of operation
// - basic fault: lamp off, fan/pump run-down
// - basic switch-on sensor and valve checks
// - flame before spark is a fault
// - no flame 25 s after start
// - basic: 12 s below supply threshold
// - extended: 20 s below supply threshold
// - no combustion over 10 s
// - basic heating sensor and valve checks
// - extended heating sensor, valve, igniter checks
// - flame 30 s into run-down, 90 s more
// - restart only after switch off then on, overheat excepted
// - extended: count shutdowns, then lockout
// - extended: flash code, 120 s run-down
// - extended switch-on component checks
// - extended start-up pump and dry-run checks
// - overheat closes valve, run-down, auto restart
// - five short, then error-number long flashes
// - error numbers one to twelve
// - no-start after 2, flame-out after 5
// - overheat recorded as flame-out
// - error code sent to timer unit
// - lockout cleared by power loss in start
// - eight starts or five flame-outs lock
// - spark at 12 s, valve 1 s later
module hfs_supervisor #(
    parameter EXTENDED = 1,
    parameter TICK_CYC = `HFS_CLK_HZ / 1000 * `HFS_TICK_MS,
    parameter FLASH_CYC = `HFS_CLK_HZ / 1000 * `HFS_FLASH_MS,
    parameter [7:0] T_RUNUP = `HFS_T_RUNUP,
    parameter [7:0] T_VALVE = `HFS_T_VALVE,
    parameter [7:0] T_NOFLAME = `HFS_T_NOFLAME,
    parameter [7:0] T_NOCOMB = `HFS_T_NOCOMB,
    parameter [7:0] T_RD_B = `HFS_T_RD_B,
    parameter [7:0] T_RD_E = `HFS_T_RD_E,
    parameter [7:0] T_XTRA = `HFS_T_XTRA,
    parameter [7:0] FL_SHORT = `HFS_FL_SHORT,
    parameter [7:0] FL_LONG = `HFS_FL_LONG,
    parameter [7:0] FL_GAP = `HFS_FL_GAP,
    parameter [7:0] FL_PAUSE = `HFS_FL_PAUSE,
    parameter [3:0] FAULT_LIMIT = `HFS_FAULT_LIMIT
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire op_switch,
    input wire flame_in,
    input wire supply_low,
    input wire tsens_short,
    input wire tsens_open,
    input wire fsens_short,
    input wire fsens_open,
    input wire valve_short,
    input wire valve_open,
    input wire ign_short,
    input wire ign_open,
    input wire fan_fault,
    input wire pump_fault,
    input wire pump_dry,
    input wire overheat_trip,
    input wire limiter_trip,
    input wire power_loss,
    input wire heat_demand,
    input wire timer_present,
    input wire lock_restore,
    output wire lamp,
    output wire fan_on,
    output wire pump_on,
    output wire spark_on,
    output wire valve_on,
    output reg [3:0] timer_code,
    output reg timer_strobe,
    output wire lock_store
);
    // first free error slot keeps the earliest check in priority
    function [3:0] pick;
        input [3:0] cur;
        input cond;
        input [3:0] code;
        begin
            pick = (cur != 4'h0) ? cur : (cond ? code : 4'h0);
        end
    endfunction

    // saturating one-step increment of a seconds counter
    function [7:0] sinc;
        input [7:0] v;
        begin
            sinc = (v == 8'hFF) ? v : v + 8'h01;
        end
    endfunction

    reg ctrl_dry_q; // dry-run checking enabled
    reg [19:0] s1_q, s2_q, s3_q, in_q; // pin synchroniser and filtered levels
    reg [31:0] tick_cnt_q; // second divider
    reg tick_q; // one-second pulse
    reg [31:0] unit_cnt_q; // flash unit divider
    reg unit_q; // flash unit pulse
    reg [1:0] init_q; // settle count after reset release
    reg [3:0] st_q; // supervisor state
    reg [7:0] sec_q, uv_q, nf_q, rd_lim_q; // second counters and run-down length
    reg xtra_q; // extended run-down already running
    reg [3:0] start_q, lstart_q, fo_q, shut_q; // attempt and failure counts
    reg [3:0] err_q; // last error number
    reg lock_q; // error lockout, mirrored to retained storage
    reg oh_q; // last fault was an overheat trip
    reg sw_off_q; // switch seen off since the fault
    reg lamp_q, fan_q, pump_q, spark_q, valve_q;
    reg [1:0] fl_ph_q; // flash phase: short group, long group
    reg [3:0] fl_n_q; // pulses shown in this phase
    reg [7:0] fl_u_q; // units spent in this half
    reg fl_on_q; // lamp half of a flash pulse

    // filtered pin levels
    wire sw = in_q[0];
    wire flame = in_q[1];
    wire uv = in_q[2];
    wire tsh = in_q[3];
    wire top = in_q[4];
    wire fsh = in_q[5];
    wire fop = in_q[6];
    wire vsh = in_q[7];
    wire vop = in_q[8];
    wire ish = in_q[9];
    wire iop = in_q[10];
    wire mot = in_q[11];
    wire pmp = in_q[12];
    wire dry = in_q[13];
    wire oh = in_q[14];
    wire lim = in_q[15];
    wire ploss = in_q[16];
    wire dem = in_q[17];
    wire tmr = in_q[18];
    wire lkr = in_q[19];

    // apb: zero wait, unmapped offsets answer with pslverr
    wire ext = (EXTENDED != 0);
    wire hit = (paddr == `HFS_REG_CTRL) | (paddr == `HFS_REG_STAT) | (paddr == `HFS_REG_ERR);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;

    // control register write
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_dry_q <= `HFS_CTRL_RST;
        end else if (psel && penable && pwrite && paddr == `HFS_REG_CTRL) begin
            ctrl_dry_q <= pwdata[`HFS_CTRL_DRY];
        end
    end

    // read data captured in the setup cycle, held for the access cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable) begin
            case (paddr)
                `HFS_REG_CTRL: prdata <= {31'h00000000, ctrl_dry_q};
                `HFS_REG_STAT: prdata <= {21'h000000, flame, valve_q, spark_q, lamp_q, pump_q, fan_q, lock_q, st_q};
                `HFS_REG_ERR: prdata <= {16'h0000, fo_q, lstart_q, shut_q, err_q};
                default: prdata <= 32'h00000000;
            endcase
        end
    end

    // three-stage synchroniser; a level counts once stages two and three agree
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_q <= 20'h00000;
            s2_q <= 20'h00000;
            s3_q <= 20'h00000;
            in_q <= 20'h00000;
        end else begin
            s1_q <= {lock_restore, timer_present, heat_demand, power_loss, limiter_trip, overheat_trip,
                     pump_dry, pump_fault, fan_fault, ign_open, ign_short, valve_open, valve_short,
                     fsens_open, fsens_short, tsens_open, tsens_short, supply_low, flame_in, op_switch};
            s2_q <= s1_q;
            s3_q <= s2_q;
            in_q <= (s2_q & s3_q) | (in_q & (s2_q ^ s3_q));
        end
    end

    // one-second tick and flash unit pulse
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt_q <= 32'h00000000;
            tick_q <= 1'b0;
            unit_cnt_q <= 32'h00000000;
            unit_q <= 1'b0;
        end else begin
            tick_q <= (tick_cnt_q == TICK_CYC - 1);
            tick_cnt_q <= (tick_cnt_q == TICK_CYC - 1) ? 32'h00000000 : tick_cnt_q + 32'h00000001;
            unit_q <= (unit_cnt_q == FLASH_CYC - 1);
            unit_cnt_q <= (unit_cnt_q == FLASH_CYC - 1) ? 32'h00000000 : unit_cnt_q + 32'h00000001;
        end
    end

    // phase decode
    wire startup = (st_q == `HFS_ST_RUNUP) | (st_q == `HFS_ST_IGN) | (st_q == `HFS_ST_FWAIT);
    wire heating = (st_q == `HFS_ST_HEAT) | (st_q == `HFS_ST_CIDLE);
    wire rundown = (st_q == `HFS_ST_RDN) | (st_q == `HFS_ST_FRDN);
    wire [7:0] uv_lim = ext ? `HFS_T_UV_E : `HFS_T_UV_B;
    wire ns_hit = (st_q == `HFS_ST_FWAIT) & ~flame & (sec_q >= T_NOFLAME);
    wire nf_hit = (st_q == `HFS_ST_HEAT) & (nf_q > T_NOCOMB);
    wire uv_hit = heating & (uv_q >= uv_lim);
    wire ns_end = (start_q + 4'h1 >= `HFS_START_TRIES) | (ext & (lstart_q + 4'h1 >= `HFS_START_LOCK));
    wire fo_end = (fo_q + 4'h1 >= `HFS_FO_LIMIT);
    wire ovh = (startup | heating) & oh;
    reg [3:0] fc; // detected fault number, 0 for none

    // fault detection by phase, earliest check wins
    always @* begin
        fc = 4'h0;
        if (st_q == `HFS_ST_RUNUP) begin
            fc = pick(fc, tsh | top, `HFS_E_TSENS);
            fc = pick(fc, fsh | fop, `HFS_E_FSENS);
            fc = pick(fc, vop | (ext & vsh), `HFS_E_VALVE);
            fc = pick(fc, ext & mot, `HFS_E_FAN);
            fc = pick(fc, ext & (ish | iop), `HFS_E_IGN);
            fc = pick(fc, flame, `HFS_E_FOREIGN);
        end
        if (startup) begin
            fc = pick(fc, ext & (pmp | (dry & ctrl_dry_q)), `HFS_E_PUMP);
            fc = pick(fc, ns_hit & ns_end, `HFS_E_NOSTART);
        end
        if (heating) begin
            fc = pick(fc, uv_hit, `HFS_E_VOLT);
            fc = pick(fc, nf_hit & fo_end, `HFS_E_FLAMEOUT);
            if (ext) begin
                fc = pick(fc, tsh, `HFS_E_TSENS);
                fc = pick(fc, fsh | fop, `HFS_E_FSENS);
                fc = pick(fc, vsh, `HFS_E_VALVE);
                fc = pick(fc, ish | iop, `HFS_E_IGN);
            end else begin
                fc = pick(fc, tsh & (st_q == `HFS_ST_CIDLE), `HFS_E_TSENS);
                fc = pick(fc, top & (st_q == `HFS_ST_HEAT), `HFS_E_TSENS);
                fc = pick(fc, fsh & (st_q == `HFS_ST_HEAT), `HFS_E_FSENS);
                fc = pick(fc, vsh & (st_q == `HFS_ST_HEAT), `HFS_E_VALVE);
            end
        end
        if (startup | heating) begin
            fc = pick(fc, lim, `HFS_E_LIMIT);
            fc = pick(fc, ovh, `HFS_E_FLAMEOUT);
        end
        if (rundown) begin
            fc = pick(fc, flame & ~xtra_q & (sec_q > `HFS_T_FL_RD), `HFS_E_FOREIGN);
        end
    end

    // lockout takes priority over the detected number
    wire lock_go = ext & (fc != 4'h0) & ((shut_q + 4'h1 >= FAULT_LIMIT) | (ns_hit & ns_end &
                   (lstart_q + 4'h1 >= `HFS_START_LOCK)) | ((nf_hit | ovh) & fo_end));
    wire [3:0] fcode = lock_go ? `HFS_E_LOCK : fc;
    wire fault_go = (fc != 4'h0);

    // supervisor sequence
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= `HFS_ST_OFF;
            sec_q <= 8'h00;
            uv_q <= 8'h00;
            nf_q <= 8'h00;
            rd_lim_q <= 8'h00;
            xtra_q <= 1'b0;
            start_q <= 4'h0;
            lstart_q <= 4'h0;
            fo_q <= 4'h0;
            shut_q <= 4'h0;
            err_q <= 4'h0;
            lock_q <= 1'b0;
            oh_q <= 1'b0;
            sw_off_q <= 1'b0;
            init_q <= 2'h0;
            timer_code <= 4'h0;
            timer_strobe <= 1'b0;
        end else begin
            timer_strobe <= 1'b0;
            // retained lockout is taken on the third clock after reset, before the filtered pins have settled
            if (init_q != 2'h3) begin
                init_q <= init_q + 2'h1;
            end
            if (init_q == 2'h2) begin
                lock_q <= lkr;
            end
            // second counters; undervoltage and no-flame need continuous presence
            if (tick_q) begin
                sec_q <= sinc(sec_q);
                uv_q <= (heating & uv) ? sinc(uv_q) : 8'h00;
                nf_q <= ((st_q == `HFS_ST_HEAT) & ~flame) ? sinc(nf_q) : 8'h00;
            end
            if (!heating) begin
                uv_q <= 8'h00;
            end
            if (fault_go) begin
                st_q <= `HFS_ST_FRDN;
                sec_q <= 8'h00;
                if (rundown && fc == `HFS_E_FOREIGN) begin
                    rd_lim_q <= T_XTRA;
                    xtra_q <= 1'b1;
                end else begin
                    rd_lim_q <= ext ? T_RD_E : T_RD_B;
                    xtra_q <= 1'b0;
                end
                err_q <= fcode;
                if (ext && shut_q != 4'hF) begin
                    shut_q <= shut_q + 4'h1;
                end
                if (lock_go) begin
                    lock_q <= 1'b1;
                end
                if (ns_hit) begin
                    lstart_q <= lstart_q + 4'h1;
                end
                if (nf_hit | ovh) begin
                    fo_q <= fo_q + 4'h1;
                end
                oh_q <= ovh;
                sw_off_q <= 1'b0;
                timer_code <= fcode;
                timer_strobe <= tmr;
            end else begin
                case (st_q)
                    `HFS_ST_OFF: begin
                        if (sw && lock_q) begin
                            // locked: error run-down only, no burner
                            st_q <= `HFS_ST_FRDN;
                            sec_q <= 8'h00;
                            rd_lim_q <= T_RD_E;
                            err_q <= `HFS_E_LOCK;
                            sw_off_q <= 1'b0;
                        end else if (sw) begin
                            st_q <= `HFS_ST_RUNUP;
                            sec_q <= 8'h00;
                            start_q <= 4'h0;
                        end
                    end
                    `HFS_ST_RUNUP: begin
                        if (!sw) begin
                            st_q <= `HFS_ST_RDN;
                        end else if (sec_q >= T_RUNUP) begin
                            st_q <= `HFS_ST_IGN;
                        end
                    end
                    `HFS_ST_IGN: begin
                        if (!sw) begin
                            st_q <= `HFS_ST_RDN;
                        end else if (sec_q >= T_RUNUP + T_VALVE) begin
                            st_q <= `HFS_ST_FWAIT;
                        end
                    end
                    `HFS_ST_FWAIT: begin
                        if (!sw) begin
                            st_q <= `HFS_ST_RDN;
                        end else if (flame) begin
                            // spark drops as soon as flame is seen
                            st_q <= `HFS_ST_HEAT;
                            sec_q <= 8'h00;
                            start_q <= 4'h0;
                            lstart_q <= 4'h0;
                            shut_q <= 4'h0;
                        end else if (ns_hit) begin
                            st_q <= `HFS_ST_RUNUP;
                            sec_q <= 8'h00;
                            start_q <= start_q + 4'h1;
                            lstart_q <= lstart_q + 4'h1;
                        end
                    end
                    `HFS_ST_HEAT: begin
                        if (!sw) begin
                            st_q <= `HFS_ST_RDN;
                        end else if (nf_hit) begin
                            // flame-out below the limit: fresh start attempt
                            st_q <= `HFS_ST_RUNUP;
                            sec_q <= 8'h00;
                            fo_q <= fo_q + 4'h1;
                        end else if (!dem) begin
                            st_q <= `HFS_ST_CIDLE;
                        end
                    end
                    `HFS_ST_CIDLE: begin
                        if (!sw) begin
                            st_q <= `HFS_ST_RDN;
                        end else if (dem) begin
                            st_q <= `HFS_ST_RUNUP;
                            sec_q <= 8'h00;
                            start_q <= 4'h0;
                        end
                    end
                    `HFS_ST_RDN: begin
                        if (sw) begin
                            st_q <= `HFS_ST_RUNUP;
                            sec_q <= 8'h00;
                            start_q <= 4'h0;
                        end else if (sec_q >= rd_lim_q) begin
                            st_q <= `HFS_ST_OFF;
                        end
                    end
                    `HFS_ST_FRDN: begin
                        if (!sw) begin
                            sw_off_q <= 1'b1;
                        end
                        if (ploss && sw && lock_q) begin
                            lock_q <= 1'b0;
                        end
                        if (sec_q >= rd_lim_q) begin
                            st_q <= `HFS_ST_HOLD;
                        end
                    end
                    `HFS_ST_HOLD: begin
                        if (!sw) begin
                            sw_off_q <= 1'b1;
                        end
                        if (sw && (sw_off_q || (oh_q && !oh && !lock_q))) begin
                            st_q <= `HFS_ST_OFF;
                            oh_q <= 1'b0;
                        end
                    end
                    default: st_q <= `HFS_ST_OFF;
                endcase
            end
            // normal switch-off: clean run-down, clears the flame-out chain
            if (!fault_go && !sw && (startup || heating)) begin
                sec_q <= 8'h00;
                rd_lim_q <= ext ? T_RD_E : T_RD_B;
                xtra_q <= 1'b0;
                fo_q <= 4'h0;
            end
        end
    end

    // flash code: five short pulses, then err_q long pulses, repeated
    wire fl_run = ext & ~tmr & (st_q == `HFS_ST_FRDN);
    wire [3:0] fl_cnt = (fl_ph_q == 2'h0) ? `HFS_SHORT_PULSES : err_q;
    wire fl_last = (fl_n_q + 4'h1 >= fl_cnt);
    wire [7:0] fl_len = fl_on_q ? ((fl_ph_q == 2'h0) ? FL_SHORT : FL_LONG)
                               : ((fl_last && fl_ph_q != 2'h0) ? FL_PAUSE : FL_GAP);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fl_ph_q <= 2'h0;
            fl_n_q <= 4'h0;
            fl_u_q <= 8'h00;
            fl_on_q <= 1'b0;
        end else if (!fl_run) begin
            fl_ph_q <= 2'h0;
            fl_n_q <= 4'h0;
            fl_u_q <= 8'h00;
            fl_on_q <= 1'b1;
        end else if (unit_q) begin
            if (fl_u_q + 8'h01 >= fl_len) begin
                fl_u_q <= 8'h00;
                fl_on_q <= ~fl_on_q;
                if (!fl_on_q) begin
                    // end of a gap: next pulse, next group, or repeat
                    fl_n_q <= fl_last ? 4'h0 : fl_n_q + 4'h1;
                    if (fl_last) begin
                        fl_ph_q <= (fl_ph_q == 2'h0) ? 2'h1 : 2'h0;
                    end
                end
            end else begin
                fl_u_q <= fl_u_q + 8'h01;
            end
        end
    end

    // actuator and lamp outputs, registered
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lamp_q <= 1'b0;
            fan_q <= 1'b0;
            pump_q <= 1'b0;
            spark_q <= 1'b0;
            valve_q <= 1'b0;
        end else begin
            lamp_q <= startup | heating | (fl_run & fl_on_q);
            fan_q <= startup | (st_q == `HFS_ST_HEAT) | rundown;
            pump_q <= startup | heating | rundown;
            spark_q <= ((st_q == `HFS_ST_IGN) | (st_q == `HFS_ST_FWAIT)) & ~flame;
            // hazard: valve must drop at once on overheat, not wait for the fsm
            valve_q <= ((st_q == `HFS_ST_FWAIT) | (st_q == `HFS_ST_HEAT)) & ~oh & ~fault_go;
        end
    end

    assign lamp = lamp_q;
    assign fan_on = fan_q;
    assign pump_on = pump_q;
    assign spark_on = spark_q;
    assign valve_on = valve_q;
    assign lock_store = lock_q;
endmodule // hfs_supervisor
`default_nettype wire

// file: bench/hfs_supervisor_assertions.sv
`default_nettype none
module hfs_supervisor_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic timer_strobe,
    input wire logic timer_present,
    input wire logic lamp,
    input wire logic fan_on,
    input wire logic pump_on,
    input wire logic spark_on,
    input wire logic valve_on,
    input wire logic [3:0] timer_code
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a reported fault; outputs settle one clock behind the state
    sequence s_fault;
        timer_strobe ##1 1'b1;
    endsequence
    a_code_range: assert property (timer_strobe |-> timer_code >= 4'h1 && timer_code <= 4'hC)
        else $error("code out of range");
    a_strobe_timer: assert property (timer_strobe |-> timer_present)
        else $error("strobe without timer");
    a_strobe_pulse: assert property (timer_strobe |=> !timer_strobe)
        else $error("strobe too long");
    a_burner_shut: assert property (s_fault |=> !valve_on && !spark_on)
        else $error("burner left on");
    a_fan_rundown: assert property (s_fault |=> fan_on && pump_on)
        else $error("no run-down");
    a_lamp_dark: assert property (s_fault |=> !lamp)
        else $error("lamp lit after fault");
    a_spark_air: assert property (spark_on |-> fan_on && pump_on)
        else $error("spark without fan");
    a_fan_stop: assert property ($fell(fan_on) |-> !valve_on && !spark_on)
        else $error("fan stopped while burning");
endmodule // hfs_supervisor_assertions
bind hfs_supervisor hfs_supervisor_assertions u_chk (.pclk, .presetn, .timer_strobe, .timer_present, .lamp, .fan_on,
    .pump_on, .spark_on, .valve_on, .timer_code);
`default_nettype wire

// file: bench/hfs_heater_model.sv
`default_nettype none
module hfs_heater_model (
    input wire logic pclk,
    input wire logic valve_on,
    input wire logic spark_on,
    input wire logic fake,
    output logic flame_in
);
    timeunit 1ns;
    timeprecision 1ns;
    logic lit_q = 1'b0; // flame burning
    // flame catches only on spark with fuel and dies with the valve
    always @(posedge pclk) lit_q <= valve_on && (lit_q || spark_on);
    // stray light lets a scenario show flame out of sequence
    assign flame_in = lit_q || fake;
endmodule // hfs_heater_model
`default_nettype wire

// file: bench/hfs_supervisor_test.sv
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; $display("FAIL %s %0h %0h", n, e, g); end end
module hfs_supervisor_test;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int T = 20; // clocks per one-second tick
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fake = 0, er, lp;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, rd;
    logic op_switch = 0, supply_low = 0, tsens_short = 0, tsens_open = 0, fsens_short = 0, fsens_open = 0;
    logic valve_short = 0, valve_open = 0, ign_short = 0, ign_open = 0, fan_fault = 0, pump_fault = 0;
    logic pump_dry = 0, overheat_trip = 0, limiter_trip = 0, power_loss = 0, heat_demand = 1;
    logic timer_present = 1, lock_restore = 0;
    wire logic [31:0] prdata;
    wire logic pready, pslverr, flame_in, lamp, fan_on, pump_on, spark_on, valve_on, timer_strobe, lock_store;
    wire logic [3:0] timer_code;
    wire logic [5:0] ev = {lamp, lock_store, timer_strobe, valve_on, spark_on, fan_on}; // waitable outputs
    int n_errors = 0, num_checks = 0, c;
    hfs_supervisor #(.TICK_CYC(T), .FLASH_CYC(4)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .op_switch, .flame_in, .supply_low, .tsens_short, .tsens_open, .fsens_short,
        .fsens_open, .valve_short, .valve_open, .ign_short, .ign_open, .fan_fault, .pump_fault, .pump_dry,
        .overheat_trip, .limiter_trip, .power_loss, .heat_demand, .timer_present, .lock_restore, .lamp, .fan_on,
        .pump_on, .spark_on, .valve_on, .timer_code, .timer_strobe, .lock_store);
    hfs_heater_model u_heat (.pclk, .valve_on, .spark_on, .fake, .flame_in);
    always #20 pclk = ~pclk;
    task automatic end_sim();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // one apb transfer; request held until pready is seen
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        c = 0;
        do begin
            @(posedge pclk);
            c++;
        end while (pready !== 1'b1 && c < 50);
        if (c >= 50) begin
            n_errors++;
            end_sim();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // bounded wait on one output; c holds the clocks taken
    task automatic wt(input int i, input logic v);
        c = 0;
        while (ev[i] !== v) begin
            @(posedge pclk);
            c++;
            if (c > 4000) begin
                n_errors++;
                end_sim();
            end
        end
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        apb(1, 8'h00, 32'h1);
        apb(0, 8'h00, 32'h0);
        `CHK("ctrl", 32'h1, rd)
        apb(1, 8'h08, 32'hFFFF);
        apb(0, 8'h08, 32'h0);
        `CHK("err", 32'h0, rd)
        apb(0, 8'h0C, 32'h0);
        `CHK("unmapped", 33'h100000000, {er, rd})
        $display("regs done");
        op_switch <= 1'b1;
        wt(1, 1'b1);
        `CHK("spark", 1'b1, c >= 11 * T && c <= 13 * T + 8)
        wt(2, 1'b1);
        `CHK("valve", 1'b1, c >= 1 && c <= 2 * T + 8)
        wt(1, 1'b0);
        apb(0, 8'h04, 32'h0);
        `CHK("heat", 4'h4, rd[3:0])
        tsens_short <= 1'b1;
        wt(3, 1'b1);
        `CHK("tsens", 4'h6, timer_code)
        tsens_short <= 1'b0;
        wt(0, 1'b0);
        `CHK("rundown", 1'b1, c >= 119 * T && c <= 121 * T + 8)
        apb(0, 8'h04, 32'h0);
        `CHK("hold", 4'h8, rd[3:0])
        op_switch <= 1'b0;
        repeat (10) @(posedge pclk);
        op_switch <= 1'b1;
        repeat (10) @(posedge pclk);
        apb(0, 8'h04, 32'h0);
        `CHK("restart", 4'h1, rd[3:0])
        $display("start and fault done");
        fake <= 1'b1;
        wt(3, 1'b1);
        `CHK("foreign", 4'h4, timer_code)
        fake <= 1'b0;
        op_switch <= 1'b0;
        repeat (10) @(posedge pclk);
        op_switch <= 1'b1;
        wt(0, 1'b0);
        fake <= 1'b1;
        wt(3, 1'b1);
        `CHK("lockout", 4'hC, timer_code)
        fake <= 1'b0;
        wt(4, 1'b1);
        power_loss <= 1'b1;
        wt(4, 1'b0);
        `CHK("unlock", 1'b1, c < 10)
        $display("lockout done");
        // switch-operated unit: lock code flashed on the lamp during run-down
        timer_present <= 1'b0;
        wt(5, 1'b1);
        c = 0;
        lp = 1'b1;
        // five short and twelve long pulses end well inside one sequence
        repeat (750) begin
            @(posedge pclk);
            if (lp && !lamp) c++;
            lp = lamp;
        end
        `CHK("flash", 17, c)
        $display("flash done");
        end_sim();
    end
endmodule // hfs_supervisor_test
`default_nettype wire
